// ### src/fcd_pkg.sv
/*
 Package for the coprocessor command decoder: opcodes, group codes,
 status-register field positions, register offsets and reset values.
 Assumes nothing of its surroundings.
*/
package fcd_pkg;
   // ****************************************************************
   // Opcodes
   // ****************************************************************
   localparam logic [4:0] OPC_ABS      = 5'h0C;
   localparam logic [4:0] OPC_ADD      = 5'h02;
   localparam logic [4:0] OPC_SUB      = 5'h03;
   localparam logic [4:0] OPC_MULTIPLY = 5'h06;
   localparam logic [4:0] OPC_DIV      = 5'h04;
   localparam logic [4:0] OPC_REMAIN   = 5'h05;
   localparam logic [4:0] OPC_ROOT     = 5'h0D;
   localparam logic [4:0] OPC_NEGATE   = 5'h17;
   localparam logic [4:0] OPC_RND_INT  = 5'h0E;
   localparam logic [4:0] OPC_CMP      = 5'h0A;
   localparam logic [4:0] OPC_CMP_EXC  = 5'h0B;
   localparam logic [4:0] OPC_CMP_SW   = 5'h1A;
   localparam logic [4:0] OPC_CMP_EXSW = 5'h1B;
   localparam logic [4:0] OPC_MOVE     = 5'h07;
   localparam logic [4:0] OPC_RD_STAT  = 5'h08;
   localparam logic [4:0] OPC_WR_STAT  = 5'h09;
   localparam logic [4:0] OPC_LD_EXC   = 5'h18;
   localparam logic [4:0] OPC_DEC2FLT  = 5'h11;
   localparam logic [4:0] OPC_FLT2DEC  = 5'h12;
   localparam logic [4:0] OPC_FLT2INT  = 5'h0F;
   localparam logic [4:0] OPC_INT2FLT  = 5'h10;
   localparam logic [4:0] OPC_ATAN     = 5'h1E;
   localparam logic [4:0] OPC_COSINE   = 5'h1D;
   localparam logic [4:0] OPC_LOAD_PI  = 5'h1F;
   localparam logic [4:0] OPC_SINE     = 5'h1C;
   localparam logic [4:0] OPC_EXTRACT  = 5'h14;
   localparam logic [4:0] OPC_NULL     = 5'h13;

   // ****************************************************************
   // Group select bits (one-hot)
   // ****************************************************************
   localparam int GRP_W     = 6;
   localparam int GRP_ARITH = 0;
   localparam int GRP_CMP   = 1;
   localparam int GRP_XFER  = 2;
   localparam int GRP_CONV  = 3;
   localparam int GRP_TRANS = 4;
   localparam int GRP_MISC  = 5;

   // ****************************************************************
   // Command word layout: opcode and three specifiers
   // ****************************************************************
   localparam int CMD_OPC_LSB = 0;
   localparam int CMD_OP1_LSB = 8;
   localparam int CMD_OP2_LSB = 12;
   localparam int CMD_OP3_LSB = 16;
   localparam logic [3:0] SPEC_NULL = 4'hF;

   // ****************************************************************
   // Status register field positions
   // ****************************************************************
   localparam int ST_N    = 0;
   localparam int ST_Z    = 1;
   localparam int ST_PREC = 2;
   localparam int ST_IS   = 3;
   localparam int ST_QS   = 4;
   localparam int ST_IM   = 5;
   localparam int ST_QM   = 6;
   localparam int ST_NTN  = 7;
   localparam int ST_ECP  = 8;
   localparam logic [31:0] ST_RESET = 32'h0000_0000;

   // ****************************************************************
   // Wishbone register offsets
   // ****************************************************************
   localparam logic [7:0] A_CMD    = 8'h00;
   localparam logic [7:0] A_STATUS = 8'h04;
   localparam logic [7:0] A_CTRL   = 8'h08;
   localparam logic [7:0] A_OPA    = 8'h0C;
   localparam logic [7:0] A_OPB    = 8'h10;
   localparam logic [7:0] A_EXC    = 8'h14;
   localparam logic [7:0] A_RESULT = 8'h18;
   localparam logic [7:0] A_GROUP  = 8'h1C;
   localparam logic [7:0] A_FREG0  = 8'h20;

   // Control register bits
   localparam int CT_INTR  = 0;
   localparam int CT_TNAN1 = 1;
   localparam int CT_TNAN2 = 2;
   localparam int CT_INV   = 3;
   localparam int CT_DZ    = 4;
   localparam int CT_DBL   = 5;
   localparam int CT_SEQ   = 6;
   localparam int CT_ACK   = 7;

   localparam int NFREG = 8;
   localparam logic [31:0] QNAN_POS = 32'h7FC0_0000;
   localparam logic [31:0] INF_POS  = 32'h7F80_0000;

   typedef enum logic [2:0] {
      S_IDLE, S_FETCH, S_EXEC, S_NARROW, S_ROUND, S_STORE, S_DONE
   } fcd_state_t;
endpackage : fcd_pkg

// ### src/fcd_decode.sv
/*
 Opcode decoder: opcode field to one-hot group select.
 Assumes the opcode comes from a latched command word.
*/
`timescale 1ns/1ps
module fcd_decode
   import fcd_pkg::*;
(
   input  wire logic [4:0]       opc_i,
   output wire logic [GRP_W-1:0] grp_o,
   output wire logic             conv_out_o,
   output wire logic             conv_in_o
);
   // ****************************************************************
   // Group match terms
   // ****************************************************************
   wire logic is_arith;
   wire logic is_cmp;
   wire logic is_xfer;
   wire logic is_conv;
   wire logic is_trans;
   // Arithmetic group
   assign is_arith = (opc_i == OPC_ABS) || (opc_i == OPC_ADD) || (opc_i == OPC_SUB)
                  || (opc_i == OPC_MULTIPLY) || (opc_i == OPC_DIV) || (opc_i == OPC_REMAIN)
                  || (opc_i == OPC_ROOT) || (opc_i == OPC_NEGATE) || (opc_i == OPC_RND_INT);
   // Compare group
   assign is_cmp   = (opc_i == OPC_CMP) || (opc_i == OPC_CMP_EXC)
                  || (opc_i == OPC_CMP_SW) || (opc_i == OPC_CMP_EXSW);
   // Transfer group
   assign is_xfer  = (opc_i == OPC_MOVE) || (opc_i == OPC_RD_STAT)
                  || (opc_i == OPC_WR_STAT) || (opc_i == OPC_LD_EXC);
   // Conversion group
   assign is_conv  = conv_out_o || conv_in_o;
   assign conv_out_o = (opc_i == OPC_FLT2DEC) || (opc_i == OPC_FLT2INT);
   assign conv_in_o  = (opc_i == OPC_DEC2FLT) || (opc_i == OPC_INT2FLT);
   // Transcendental group
   assign is_trans = (opc_i == OPC_ATAN) || (opc_i == OPC_COSINE)
                  || (opc_i == OPC_LOAD_PI) || (opc_i == OPC_SINE);
   // Anything unassigned falls into the misc group and runs as the null op
   assign grp_o[GRP_ARITH] = is_arith;
   assign grp_o[GRP_CMP]   = is_cmp;
   assign grp_o[GRP_XFER]  = is_xfer;
   assign grp_o[GRP_CONV]  = is_conv;
   assign grp_o[GRP_TRANS] = is_trans;
   assign grp_o[GRP_MISC]  = !(is_arith || is_cmp || is_xfer || is_conv || is_trans);
endmodule : fcd_decode

// ### src/fcd_top.sv
/*
 Command sequencer of the floating-point coprocessor with its status,
 exception data and float register context, on a classic Wishbone slave.
 Assumes a single clock and a host that keeps to the coprocessor protocol.
*/
`timescale 1ns/1ps
module fcd_top
   import fcd_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             done_n_o,
   output logic             fault_o,
   output logic             fetch_o,
   output logic             store_o
);
   // ****************************************************************
   // State
   // ****************************************************************
   fcd_state_t        state_ff, nxt_state;
   logic [31:0]       cmd_ff;
   logic [31:0]       status_ff, nxt_status;
   logic [7:0]        ctrl_ff;
   logic [31:0]       opa_ff, opb_ff;
   logic [31:0]       exc_ff, nxt_exc;
   logic [31:0]       res_ff, nxt_res;
   logic [1:0]        fetch_cnt_ff;
   logic [31:0]       freg_ff [NFREG];
   logic              fault_ff, nxt_fault;

   // ****************************************************************
   // Bus decode
   // ****************************************************************
   wire logic        bus_req;
   wire logic        wr_hit;
   wire logic        rd_hit;
   wire logic [31:0] wmask;
   wire logic        freg_sel;
   wire logic [2:0]  freg_idx;
   // Ack term stops a held request being taken twice
   assign bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_hit   = bus_req && wb_we_i;
   assign rd_hit   = bus_req && !wb_we_i;
   assign wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   // Float registers fill offsets 0x20 to 0x3F, just above the control words
   assign freg_sel = (wb_adr_i[7:5] == A_FREG0[7:5]);
   assign freg_idx = wb_adr_i[4:2];

   // ****************************************************************
   // Command fields and decode
   // ****************************************************************
   wire logic [4:0]       opc;
   wire logic [GRP_W-1:0] grp;
   wire logic             conv_out;
   wire logic             conv_in;
   wire logic             use_op1;
   wire logic             use_op2;
   wire logic             use_op3;
   wire logic             cmd_take;
   wire logic [31:0]      cmd_cur;
   assign opc     = cmd_ff[CMD_OPC_LSB +: 5];
   // A command taken now is not in cmd_ff yet, so
   // its specifiers come from the bus for fetch_o
   assign cmd_take = wr_hit && !freg_sel && (wb_adr_i == A_CMD) && (state_ff == S_IDLE);
   assign cmd_cur  = cmd_take ? wb_dat_i : cmd_ff;
   // Specifiers are obeyed whatever the opcode needs
   assign use_op1 = cmd_cur[CMD_OP1_LSB +: 4] != SPEC_NULL;
   assign use_op2 = cmd_cur[CMD_OP2_LSB +: 4] != SPEC_NULL;
   assign use_op3 = cmd_cur[CMD_OP3_LSB +: 4] != SPEC_NULL;

   fcd_decode u_dec (
      .opc_i      (opc),
      .grp_o      (grp),
      .conv_out_o (conv_out),
      .conv_in_o  (conv_in)
   );

   // ****************************************************************
   // Exception classification, taken from the control register
   // ****************************************************************
   wire logic inv_case;
   wire logic dz_case;
   wire logic inv_trap;
   wire logic nan_trap;
   wire logic dz_trap;
   wire logic exc_hit;
   wire logic intr_abort;
   wire logic is_null;
   assign is_null    = grp[GRP_MISC] && (opc != OPC_EXTRACT);
   // Null codes raise no case, so they leave status and exception data alone
   assign inv_case   = ctrl_ff[CT_INV] && !is_null;
   // Invalid outranks divide-by-zero if both set
   assign dz_case    = ctrl_ff[CT_DZ] && !is_null && !inv_case;
   assign inv_trap   = inv_case && status_ff[ST_IM];
   assign nan_trap   = inv_case && !status_ff[ST_IM] && status_ff[ST_NTN];
   assign dz_trap    = dz_case && status_ff[ST_QM];
   // Any trap ends the command with a fault
   assign exc_hit    = inv_trap || nan_trap || dz_trap;
   // An interrupt only aborts while completion has not yet been shown
   assign intr_abort = ctrl_ff[CT_INTR] && (state_ff != S_IDLE) && (state_ff != S_DONE);

   // ****************************************************************
   // Sequencer: fetch, execute, narrow, round, store
   // ****************************************************************
   always_comb begin
      nxt_state  = state_ff;
      nxt_status = status_ff;
      nxt_exc    = exc_ff;
      nxt_res    = res_ff;
      nxt_fault  = fault_ff;
      // Bus writes first; execute below wins a tie
      if (wr_hit && !freg_sel && wb_adr_i == A_STATUS) begin
         nxt_status = (status_ff & ~wmask) | (wb_dat_i & wmask);
      end
      if (wr_hit && !freg_sel && wb_adr_i == A_EXC) begin
         nxt_exc = (exc_ff & ~wmask) | (wb_dat_i & wmask);
      end
      if (intr_abort) begin
         nxt_state = S_IDLE;
      end else begin
         unique case (state_ff)
            S_IDLE: begin
               // New command clears the old fault
               if (wr_hit && !freg_sel && wb_adr_i == A_CMD) begin
                  nxt_state = S_FETCH;
                  nxt_fault = 1'b0;
               end
            end
            S_FETCH: begin
               // Unused fetched data is simply dropped
               if (fetch_cnt_ff == 2'd2) begin
                  nxt_state = S_EXEC;
               end
            end
            S_EXEC: begin
               nxt_state = S_NARROW;
               unique case (opc)
                  OPC_ADD:      nxt_res = opa_ff + opb_ff;
                  OPC_SUB:      nxt_res = opa_ff - opb_ff;
                  OPC_NEGATE:   nxt_res = {~opa_ff[31], opa_ff[30:0]};
                  OPC_ABS:      nxt_res = {1'b0, opa_ff[30:0]};
                  OPC_MOVE:     nxt_res = opa_ff;
                  OPC_RD_STAT:  nxt_res = status_ff;
                  OPC_EXTRACT:  nxt_res = exc_ff;
                  default:      nxt_res = res_ff;
               endcase
               if (opc == OPC_WR_STAT) begin
                  nxt_status = opa_ff;
               end
               if (opc == OPC_LD_EXC) begin
                  nxt_exc = opa_ff;
               end
               // Mask, then NaN trap, else quiet NaN
               if (inv_case) begin
                  nxt_status[ST_IS] = 1'b1;
                  if (inv_trap || nan_trap) begin
                     nxt_status[ST_ECP] = 1'b1;
                     nxt_status[ST_Z]   = 1'b0;
                     if (conv_in) begin
                        nxt_exc = exc_ff;
                     end else if (conv_out || nan_trap) begin
                        nxt_exc = opa_ff;
                     end else begin
                        nxt_exc = ctrl_ff[CT_TNAN1] ? opa_ff : opb_ff;
                     end
                     if (!ctrl_ff[CT_DBL] && !conv_in) begin
                        nxt_status[ST_PREC] = 1'b1;
                     end
                  end else begin
                     nxt_res = QNAN_POS;
                  end
               end
               if (dz_case) begin
                  nxt_status[ST_QS] = 1'b1;
                  if (!dz_trap) begin
                     nxt_res = {opa_ff[31] ^ opb_ff[31], INF_POS[30:0]};
                  end
               end
            end
            S_NARROW: begin
               // Narrow stage passes the result on unchanged and moves to rounding
               nxt_state = S_ROUND;
            end
            S_ROUND: begin
               nxt_state = S_STORE;
               if (exc_hit && !inv_case) begin
                  nxt_exc = res_ff;
               end
            end
            S_STORE: begin
               nxt_state = S_DONE;
               nxt_fault = exc_hit;
               // Trapped results leave N alone; an invalid trap has already cleared Z
               if (!exc_hit && !is_null && grp[GRP_ARITH]) begin
                  nxt_status[ST_N] = res_ff[31];
                  nxt_status[ST_Z] = (res_ff[30:0] == 31'h0000_0000);
               end
            end
            S_DONE: begin
               // Status fetch acknowledge ends the transaction
               if (ctrl_ff[CT_ACK]) begin
                  nxt_state = S_IDLE;
               end
            end
         endcase
      end
   end

   // ****************************************************************
   // Read mux
   // ****************************************************************
   wire logic [31:0] rd_data;
   // Unmapped offsets read as zero
   assign rd_data = freg_sel                 ? freg_ff[freg_idx] :
                    (wb_adr_i == A_CMD)      ? cmd_ff :
                    (wb_adr_i == A_STATUS)   ? status_ff :
                    (wb_adr_i == A_CTRL)     ? {24'h00_0000, ctrl_ff} :
                    (wb_adr_i == A_OPA)      ? opa_ff :
                    (wb_adr_i == A_OPB)      ? opb_ff :
                    (wb_adr_i == A_EXC)      ? exc_ff :
                    (wb_adr_i == A_RESULT)   ? res_ff :
                    (wb_adr_i == A_GROUP)    ? {21'h00_0000, state_ff, 2'h0, grp} :
                    32'h0000_0000;

   // ****************************************************************
   // Registers
   // ****************************************************************
   // Sequencer state and its context words
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_ff     <= S_IDLE;
         status_ff    <= ST_RESET;
         exc_ff       <= 32'h0000_0000;
         res_ff       <= 32'h0000_0000;
         fault_ff     <= 1'b0;
      end else begin
         state_ff     <= nxt_state;
         status_ff    <= nxt_status;
         exc_ff       <= nxt_exc;
         res_ff       <= nxt_res;
         fault_ff     <= nxt_fault;
      end
   end

   // Command, control and operand words written by software
   // Busy-time command writes are dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cmd_ff  <= {12'h000, SPEC_NULL, SPEC_NULL, SPEC_NULL, 3'h0, OPC_NULL};
         ctrl_ff <= 8'h00;
         opa_ff  <= 32'h0000_0000;
         opb_ff  <= 32'h0000_0000;
      end else if (wr_hit && !freg_sel) begin
         if (wb_adr_i == A_CMD && state_ff == S_IDLE) cmd_ff <= wb_dat_i;
         if (wb_adr_i == A_CTRL && wb_sel_i[0]) ctrl_ff <= wb_dat_i[7:0];
         if (wb_adr_i == A_OPA) opa_ff <= (opa_ff & ~wmask) | (wb_dat_i & wmask);
         if (wb_adr_i == A_OPB) opb_ff <= (opb_ff & ~wmask) | (wb_dat_i & wmask);
      end
   end

   // ****************************************************************
   // Fetch counter
   // ****************************************************************
   // Walks three fetch cycles, counts 0 to 2, used or not
   always_ff @(posedge clk_i) begin
      if (rst_i || state_ff != S_FETCH) begin
         fetch_cnt_ff <= 2'd0;
      end else begin
         fetch_cnt_ff <= fetch_cnt_ff + 2'd1;
      end
   end

   // ****************************************************************
   // Float register context
   // ****************************************************************
   // Bus writes outrank the store stage
   genvar gi;
   generate
      for (gi = 0; gi < NFREG; gi++) begin : g_freg
         always_ff @(posedge clk_i) begin
            if (rst_i) begin
               freg_ff[gi] <= 32'h0000_0000;
            end else if (wr_hit && freg_sel && freg_idx == gi) begin
               freg_ff[gi] <= (freg_ff[gi] & ~wmask) | (wb_dat_i & wmask);
            end else if (state_ff == S_STORE && use_op3 && !exc_hit
                         && cmd_ff[CMD_OP3_LSB +: 3] == gi && !cmd_ff[CMD_OP3_LSB + 3]) begin
               freg_ff[gi] <= res_ff;
            end
         end
      end
   endgenerate

   // ****************************************************************
   // Bus answer and pins
   // ****************************************************************
   // All pins are registered; done, fault, fetch and store come from next-state terms
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
         done_n_o <= 1'b1;
         fault_o  <= 1'b0;
         fetch_o  <= 1'b0;
         store_o  <= 1'b0;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= rd_hit ? rd_data : 32'h0000_0000;
         done_n_o <= !(nxt_state == S_DONE);
         fault_o  <= nxt_fault && (nxt_state == S_DONE);
         fetch_o  <= (nxt_state == S_FETCH) && (use_op1 || use_op2);
         store_o  <= (nxt_state == S_STORE) && use_op3;
      end
   end
endmodule : fcd_top

// ### bench/fcd_properties.sv
/* Checker on the top-level ports of the command decoder.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/1ps
module fcd_checker (
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        done_n_o,
   input wire logic        fault_o,
   input wire logic        fetch_o,
   input wire logic        store_o
);
   // One domain, so clock and reset are given once
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   wire logic req = wb_cyc_i & wb_stb_i;
   wire logic wreq = req & wb_we_i;
   property p_ack_next; req && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack_next: assert property (p_ack_next) else $error("request not answered");
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
   a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
   property p_fault_done; fault_o |-> !done_n_o; endproperty
   a_fault_done: assert property (p_fault_done) else $error("fault without completion");
   property p_store_pulse; store_o |=> !store_o; endproperty
   a_store_pulse: assert property (p_store_pulse) else $error("store longer than one cycle");
   property p_store_done; store_o |-> ##[1:2] !done_n_o; endproperty
   a_store_done: assert property (p_store_done) else $error("no completion after store");
   property p_fetch_busy; fetch_o |-> done_n_o && !store_o; endproperty
   a_fetch_busy: assert property (p_fetch_busy) else $error("fetch outside busy phase");
   property p_done_hold; !done_n_o && !wreq |=> !done_n_o; endproperty
   a_done_hold: assert property (p_done_hold) else $error("completion dropped alone");
   property p_done_release; $rose(done_n_o) |-> $past(wreq); endproperty
   a_done_release: assert property (p_done_release) else $error("completion released unasked");
endmodule : fcd_checker
bind fcd_top fcd_checker u_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
   .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .done_n_o, .fault_o, .fetch_o, .store_o);

// ### bench/fcd_host.sv
/* Host model: classic Wishbone master, one access at a time.
   Assumes the slave answers with ack; the bench bounds every wait. */
`timescale 1ns/1ps
module fcd_host (
   input  wire logic        clk_i,
   input  wire logic        ack_i,
   input  wire logic [31:0] dat_i,
   output logic             cyc_o,
   output logic             stb_o,
   output logic             we_o,
   output logic [7:0]       adr_o,
   output logic [3:0]       sel_o,
   output logic [31:0]      dat_o
);
   initial {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} = '0;
   // Callers never overlap calls, so one transaction is ever open
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk_i);
      {cyc_o, stb_o, we_o, adr_o, sel_o, dat_o} <= {2'b11, w, a, 4'hF, d};
      do @(posedge clk_i); while (ack_i !== 1'b1);
      q = dat_i;
      {cyc_o, stb_o, we_o} <= 3'b000;
      // Released data flips so a stale value cannot pass
      dat_o <= ~d;
   endtask : xfer
endmodule : fcd_host

// ### bench/tb_top.sv
/* Bench for the command decoder: opcode groups, specifiers, exceptions,
   abort and context order. Assumes the package register map. */
`timescale 1ns/1ps
module tb_top
   import fcd_pkg::*;
;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   wire logic cyc, stb, we, ack, done_n, fault, fetch, store;
   wire logic [7:0] adr;
   wire logic [3:0] sel;
   wire logic [31:0] wdat, rdat;
   int miscompares = 0;
   int comparisons = 0;
   int fcnt, scnt;
   logic [31:0] q;
   localparam logic [31:0] OPA_V = 32'h7FA0_0001;
   localparam logic [31:0] OPB_V = 32'h3F80_0000;
   localparam logic [31:0] ST_IN [8] = '{32'h23, 32'h23, 32'h0, 32'h80, 32'h0, 32'h40, 32'h20, 32'h20};
   localparam logic [31:0] CT_IN [8] = '{32'h0A, 32'h0C, 32'h08, 32'h0A, 32'h10, 32'h10, 32'h2C, 32'h0A};
   localparam logic [31:0] CMD_T [8] = '{32'hFF02, 32'hFF02, 32'hFF02, 32'hFF02, 32'h1FF04, 32'h1FF04,
                                         32'hFF0F, 32'hFF10};
   localparam logic        FLT [8] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
   localparam logic [31:0] ST_X [8] = '{32'h12D, 32'h12D, 32'h8, 32'h18C, 32'h10, 32'h50, 32'h128, 32'h128};
   localparam logic [31:0] ST_M [8] = '{32'h1FF, 32'h1FF, 32'h1FF, 32'h1FF, 32'h1F8, 32'h1F8, 32'h1FF, 32'h1FF};
   localparam logic [7:0]  D_A [8] = '{A_EXC, A_EXC, A_FREG0, A_EXC, 8'h24, A_OPA, A_EXC, A_OPA};
   localparam logic [31:0] D_X [8] = '{OPA_V, OPB_V, QNAN_POS, OPA_V, INF_POS, OPA_V, OPA_V, OPA_V};
   initial forever #12.5 clk_i = ~clk_i;
   fcd_top dut (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
      .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .done_n_o(done_n),
      .fault_o(fault), .fetch_o(fetch), .store_o(store));
   fcd_host host (.clk_i, .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb), .we_o(we),
      .adr_o(adr), .sel_o(sel), .dat_o(wdat));
   // Count operand fetch cycles and store pulses of each command
   always @(posedge clk_i) begin
      if (fetch === 1'b1) fcnt++;
      if (store === 1'b1) scnt++;
   end
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] x;
      host.xfer(1'b1, a, d, x);
   endtask : wr
   task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string n);
      host.xfer(1'b0, a, 32'h0, q);
      chk(n, q & m, e);
   endtask : rdc
   // Issue a command and wait, bounded, for completion
   task automatic run(input logic [31:0] c, input logic f);
      int n = 0;
      fcnt = 0;
      scnt = 0;
      wr(A_CMD, c);
      while (done_n !== 1'b0 && n < 40) begin
         @(posedge clk_i);
         n++;
      end
      chk("done_n", {31'h0, done_n}, 32'h0);
      chk("fault", {31'h0, fault}, {31'h0, f});
   endtask : run
   // Status fetch acknowledge, then clear the control word
   task automatic clr();
      wr(A_CTRL, 32'h80);
      wr(A_CTRL, 32'h0);
   endtask : clr
   function automatic logic [5:0] grp_of(input logic [4:0] o);
      case (o)
         5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h0C, 5'h0D, 5'h0E, 5'h17: return 6'h01;
         5'h0A, 5'h0B, 5'h1A, 5'h1B: return 6'h02;
         5'h07, 5'h08, 5'h09, 5'h18: return 6'h04;
         5'h0F, 5'h10, 5'h11, 5'h12: return 6'h08;
         5'h1C, 5'h1D, 5'h1E, 5'h1F: return 6'h10;
         default: return 6'h20;
      endcase
   endfunction : grp_of
   task automatic summarize();
      if (miscompares == 0 && comparisons > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : summarize
   initial begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      summarize();
   end
   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      rdc(A_STATUS, '1, ST_RESET, "status");
      // Every opcode with null specifiers: group, no fetch, no store
      for (int i = 0; i < 32; i++) begin
         run({12'h0, 12'hFFF, 3'h0, i[4:0]}, 1'b0);
         rdc(A_GROUP, 32'h3F, {26'h0, grp_of(i[4:0])}, "group");
         chk("fetch", 32'(fcnt), 32'h0);
         chk("store", 32'(scnt), 32'h0);
         clr();
      end
      // Non-null specifiers move data even for the null opcode
      run(32'h0002_F013, 1'b0);
      chk("fetch", 32'(fcnt > 0), 32'h1);
      chk("store", 32'(scnt), 32'h1);
      clr();
      // Invalid and divide-by-zero cases, masked and unmasked
      wr(A_OPA, OPA_V);
      wr(A_OPB, OPB_V);
      for (int i = 0; i < 8; i++) begin
         wr(A_STATUS, ST_IN[i]);
         wr(A_CTRL, CT_IN[i]);
         run(CMD_T[i], FLT[i]);
         clr();
         rdc(A_STATUS, ST_M[i], ST_X[i], "status");
         rdc(D_A[i], (i == 4) ? 32'h7FFF_FFFF : '1, D_X[i], "data");
      end
      // Interrupt while busy abandons the command
      wr(A_CMD, 32'h000F_FF02);
      wr(A_CTRL, 32'h01);
      repeat (20) @(posedge clk_i);
      chk("done_n", {31'h0, done_n}, 32'h1);
      rdc(A_GROUP, 32'h700, {21'h0, 3'(S_IDLE), 8'h0}, "state");
      wr(A_CTRL, 32'h0);
      wr(8'h40, 32'hFFFF_FFFF);
      rdc(8'h40, '1, 32'h0, "unmapped");
      // Context restore order, then save order with readback
      wr(A_STATUS, 32'h0);
      for (int i = 0; i < NFREG; i++) wr(A_FREG0 + 8'(4 * i), 32'hC0DE_0000 + i);
      wr(A_STATUS, 32'h21);
      wr(A_EXC, 32'h1234_5678);
      rdc(A_EXC, '1, 32'h1234_5678, "exc");
      rdc(A_STATUS, '1, 32'h21, "status");
      wr(A_STATUS, 32'h0);
      for (int i = 0; i < NFREG; i++) rdc(A_FREG0 + 8'(4 * i), '1, 32'hC0DE_0000 + i, "freg");
      summarize();
   end
endmodule : tb_top
